// ==== src/cmsc_pkg.sv ====
// Package: register map, field layout, divide ratios and carrier types of the codec configuration block
package cmsc_pkg;

   // ------------------------------------------------------------------
   // Register offsets and widths
   // ------------------------------------------------------------------
   localparam logic [7:0] CMSC_OFF_MODE = 8'h70;
   localparam logic [7:0] CMSC_OFF_SCR  = 8'h71;
   localparam logic [7:0] CMSC_OFF_CLK  = 8'h72;
   localparam int         CMSC_REG_W    = 16;
   localparam int         CMSC_LFSR_W   = 10;

   // ------------------------------------------------------------------
   // Reset values, all zero except the LFSR seed of 1
   // ------------------------------------------------------------------
   localparam logic [2:0]  CMSC_RST_MODE = 3'h0;
   localparam logic [15:0] CMSC_RST_SCR  = 16'h0000;
   localparam logic [15:0] CMSC_RST_CLK  = 16'h0000;
   localparam logic [9:0]  CMSC_LFSR_SEED = 10'h001;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int CMSC_MODE_TOP    = 2;
   localparam int CMSC_SCR_TX_EN   = 15;
   localparam int CMSC_SCR_TX_PRBS = 14;
   localparam int CMSC_SCR_TX_INV  = 13;
   localparam int CMSC_SCR_RX_EN   = 12;
   localparam int CMSC_SCR_RX_PRBS = 11;
   localparam int CMSC_SCR_RX_INV  = 10;
   localparam int CMSC_SCR_POLY_HI = 9;
   localparam int CMSC_CLK_PRE_EN  = 15;
   localparam int CMSC_CLK_DEC_EN  = 14;
   localparam int CMSC_CLK_ENC_EN  = 13;
   localparam int CMSC_CLK_FPRE_HI = 12;
   localparam int CMSC_CLK_FPRE_LO = 11;
   localparam int CMSC_CLK_FDIV_HI = 10;
   localparam int CMSC_CLK_FDIV_LO = 8;
   localparam int CMSC_CLK_BPRE_HI = 7;
   localparam int CMSC_CLK_BPRE_LO = 6;
   localparam int CMSC_CLK_DDIV_HI = 5;
   localparam int CMSC_CLK_DDIV_LO = 3;
   localparam int CMSC_CLK_EDIV_HI = 2;
   localparam int CMSC_CLK_EDIV_LO = 0;

   // ------------------------------------------------------------------
   // Divide ratios in thousandths and the fixed post divider
   // ------------------------------------------------------------------
   localparam logic [15:0] CMSC_FRAC_STEP = 16'h03E8;   // 1.000
   localparam logic [15:0] CMSC_FILT_RATIO [8] = '{16'h03E8, 16'h0FA0, 16'h1E46, 16'h1E69,
                                                   16'h1F40, 16'h2AF8, 16'h3D09, 16'h5B4F};
   localparam logic [15:0] CMSC_BIT_RATIO  [8] = '{16'h03E8, 16'h07D0, 16'h08CA, 16'h0A41,
                                                   16'h0BB8, 16'h0C35, 16'h0D2F, 16'h0DAC};
   localparam logic [5:0]  CMSC_POST_LAST = 6'h3F;       // Divide by 64

   // ------------------------------------------------------------------
   // Carrier types
   // ------------------------------------------------------------------
   typedef struct packed {
      logic adaptive_delta_modulation;
      logic buffered;
      logic linear;
      logic mulaw;
      logic alaw;
   } cmsc_mode_t;

   typedef struct packed {
      logic       tick;
      logic [1:0] cnt;
   } cmsc_pre_t;

   typedef struct packed {
      logic        tick;
      logic [15:0] acc;
   } cmsc_frac_t;

   // Integer pre-scaler step: sel is divide ratio minus one
   function automatic cmsc_pre_t cmsc_pre_step(input logic [1:0] cnt, input logic [1:0] sel);
      cmsc_pre_t r;
      r.tick = (cnt >= sel);
      r.cnt  = r.tick ? 2'h0 : 2'(cnt + 2'h1);
      return r;
   endfunction

   // Fractional step: alternates integer periods so the mean equals ratio/1000
   function automatic cmsc_frac_t cmsc_frac_step(input logic [15:0] acc, input logic [15:0] ratio);
      cmsc_frac_t  r;
      logic [16:0] sum;
      sum    = {1'b0, acc} + {1'b0, CMSC_FRAC_STEP};
      r.tick = (sum >= {1'b0, ratio});
      r.acc  = r.tick ? 16'(sum - {1'b0, ratio}) : sum[15:0];
      return r;
   endfunction

   // LFSR feedback: coefficient n taps stage n
   function automatic logic cmsc_feedback(input logic [9:0] lfsr, input logic [9:0] poly);
      return ^(lfsr & poly);
   endfunction

endpackage

// ==== src/cmsc_fifo.sv ====
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module cmsc_fifo
   import cmsc_pkg::*;
#(
   parameter int W = 1,
   parameter int D = 8
) (
   // Clock and reset
   input  wire logic         i_clk,
   input  wire logic         i_resetn,
   // Fill side
   input  wire logic         i_in_valid,
   input  wire logic [W-1:0] i_in_data,
   output logic              o_in_ready,
   // Drain side
   output logic              o_out_valid,
   output logic [W-1:0]      o_out_data,
   input  wire logic         i_out_ready
);
   localparam int AW = $clog2(D);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0]       wp;
      logic [AW-1:0]       rp;
      logic [AW:0]         cnt;
      logic                ready;
   } cmsc_fifo_st_t;

   cmsc_fifo_st_t s_r;
   cmsc_fifo_st_t s_nxt;
   logic          push;
   logic          pop;

   // Handshakes on both sides
   assign push = i_in_valid & s_r.ready;
   assign pop  = i_out_ready & (s_r.cnt != '0);

   // Next state: pointers wrap at depth, ready is a registered not-full
   always_comb begin
      s_nxt = s_r;
      if (push) begin
         s_nxt.mem[s_r.wp] = i_in_data;
         s_nxt.wp = (s_r.wp == AW'(D - 1)) ? '0 : AW'(s_r.wp + 1'b1);
      end
      if (pop) begin
         s_nxt.rp = (s_r.rp == AW'(D - 1)) ? '0 : AW'(s_r.rp + 1'b1);
      end
      s_nxt.cnt   = (AW+1)'(s_r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
      s_nxt.ready = (s_nxt.cnt != (AW+1)'(D));
   end

   // State register
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         s_r       <= '0;
         s_r.ready <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs
   assign o_in_ready  = s_r.ready;
   assign o_out_valid = (s_r.cnt != '0);
   assign o_out_data  = s_r.mem[s_r.rp];

endmodule

// ==== src/cmsc_top.sv ====
// Codec mode decode, scrambler pair and clock divider chain configuration block
//
// Behaviour
// - Mode 0 is delta modulation unbuffered, mode 1 delta modulation buffered.
// - Mode 2 linear PCM, 3 mu-law, top bit set A-law; PCM buffered.
// - Scrambler control bit 15 enables the transmit scrambler.
// - Scrambler bit 14 makes the scrambler emit its free-running sequence.
// - Scrambler bit 13 inverts every bit leaving the scrambler.
// - Scrambler bit 12 enables the receive de-scrambler.
// - Scrambler bit 11 makes the de-scrambler emit its pseudo-random sequence.
// - Scrambler bit 10 inverts every bit leaving the de-scrambler.
// - Low ten bits set the shared feedback polynomial, bit n for x^(n+1).
// - Clock divider bit 15 enables the pre-scaler stages.
// - Clock divider bit 14 runs the decode bit clock, else stopped.
// - Clock divider bit 13 runs the encode bit clock, else stopped.
// - Filter pre-scaler divides 1 to 4; filter divider by eight listed ratios.
// - Bit clock pre-scaler divides by 1, 2, 3 or 4.
// - Decode and encode dividers divide by 1 up to 3.5 in eight steps.
// - Encode and decode bit clocks are further divided by 64.
`timescale 1ns/100ps
module cmsc_top
   import cmsc_pkg::*;
#(
   parameter int FIFO_DEPTH = 8
) (
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_resetn,
   // Register port
   input  wire logic        i_reg_wr,
   input  wire logic        i_reg_rd,
   input  wire logic [7:0]  i_reg_addr,
   input  wire logic [15:0] i_reg_wdata,
   output logic      [15:0] o_reg_rdata,
   // Transmit bit stream in
   input  wire logic        i_tx_valid,
   input  wire logic        i_tx_data,
   output logic             o_tx_ready,
   // Transmit bit stream out
   output logic             o_tx_valid,
   output logic             o_tx_bit,
   // Receive pin and de-scrambled stream
   input  wire logic        i_rx_pin,
   output logic             o_rx_valid,
   output logic             o_rx_bit,
   // Clock ticks and decoded mode
   output logic             o_filt_tick,
   output logic             o_enc_tick,
   output logic             o_dec_tick,
   output cmsc_mode_t       o_mode
);

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [2:0]  mode;
      logic [15:0] scr;
      logic [15:0] clk;
      logic [1:0]  fpre_cnt;
      logic [1:0]  bpre_cnt;
      logic [15:0] facc;
      logic [15:0] eacc;
      logic [15:0] dacc;
      logic [5:0]  epost;
      logic [5:0]  dpost;
      logic        filt_tick;
      logic        enc_clk;
      logic        dec_clk;
      logic [9:0]  tx_lfsr;
      logic [9:0]  rx_lfsr;
      logic        tx_valid;
      logic        tx_bit;
      logic        rx_s1;
      logic        rx_s2;
      logic        rx_valid;
      logic        rx_bit;
      logic [15:0] rdata;
      cmsc_mode_t  mode_dec;
   } cmsc_core_t;

   cmsc_core_t s_r;
   cmsc_core_t s_nxt;
   logic       fifo_valid;
   logic       fifo_data;
   logic       fifo_pop;
   logic       tx_fb;
   logic       rx_fb;
   logic [9:0] poly;
   logic [1:0] fsel;
   logic [1:0] bsel;

   // ------------------------------------------------------------------
   // Mode decode
   // ------------------------------------------------------------------
   function automatic cmsc_mode_t mode_decode(input logic [2:0] m);
      cmsc_mode_t d;
      d = '0;
      if (m[CMSC_MODE_TOP]) begin
         d.alaw     = 1'b1;
         d.buffered = 1'b1;
      end else begin
         unique case (m[1:0])
            2'h0: d.adaptive_delta_modulation = 1'b1;
            2'h1: begin
               d.adaptive_delta_modulation      = 1'b1;
               d.buffered = 1'b1;
            end
            2'h2: begin
               d.linear   = 1'b1;
               d.buffered = 1'b1;
            end
            2'h3: begin
               d.mulaw    = 1'b1;
               d.buffered = 1'b1;
            end
         endcase
      end
      return d;
   endfunction

   // ------------------------------------------------------------------
   // Transmit buffer
   // ------------------------------------------------------------------
   // Drained only on encode bit clock ticks, so a stopped clock stalls the source
   assign fifo_pop = s_r.enc_clk & ~(s_r.scr[CMSC_SCR_TX_EN] & s_r.scr[CMSC_SCR_TX_PRBS]);

   cmsc_fifo #(
      .W (1),
      .D (FIFO_DEPTH)
   ) u_tx_fifo (
      .i_clk       (i_clk),
      .i_resetn    (i_resetn),
      .i_in_valid  (i_tx_valid),
      .i_in_data   (i_tx_data),
      .o_in_ready  (o_tx_ready),
      .o_out_valid (fifo_valid),
      .o_out_data  (fifo_data),
      .i_out_ready (fifo_pop)
   );

   // Shared polynomial feeds both sequence generators
   assign poly  = s_r.scr[CMSC_SCR_POLY_HI:0];
   assign tx_fb = cmsc_feedback(s_r.tx_lfsr, poly);
   assign rx_fb = cmsc_feedback(s_r.rx_lfsr, poly);

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      cmsc_pre_t  fp;
      cmsc_pre_t  bp;
      cmsc_frac_t ff;
      cmsc_frac_t ef;
      cmsc_frac_t df;
      logic       sb;
      fp   = '0;
      bp   = '0;
      ff   = '0;
      ef   = '0;
      df   = '0;
      sb   = 1'b0;
      s_nxt = s_r;
      s_nxt.filt_tick = 1'b0;
      s_nxt.enc_clk   = 1'b0;
      s_nxt.dec_clk   = 1'b0;
      s_nxt.tx_valid  = 1'b0;
      s_nxt.rx_valid  = 1'b0;
      s_nxt.rx_s1     = i_rx_pin;
      s_nxt.rx_s2     = s_r.rx_s1;
      s_nxt.mode_dec  = mode_decode(s_r.mode);

      // Register writes and reads
      if (i_reg_wr) begin
         unique case (i_reg_addr)
            CMSC_OFF_MODE: s_nxt.mode = i_reg_wdata[2:0];
            CMSC_OFF_SCR:  s_nxt.scr  = i_reg_wdata;
            CMSC_OFF_CLK:  s_nxt.clk  = i_reg_wdata;
            default:       s_nxt.mode = s_r.mode;
         endcase
      end
      if (i_reg_rd) begin
         unique case (i_reg_addr)
            CMSC_OFF_MODE: s_nxt.rdata = {13'h0000, s_r.mode};
            CMSC_OFF_SCR:  s_nxt.rdata = s_r.scr;
            CMSC_OFF_CLK:  s_nxt.rdata = s_r.clk;
            default:       s_nxt.rdata = 16'h0000;
         endcase
      end

      // Pre-scalers act only while enabled, else they pass every cycle
      fsel = s_r.clk[CMSC_CLK_PRE_EN] ? s_r.clk[CMSC_CLK_FPRE_HI:CMSC_CLK_FPRE_LO] : 2'h0;
      bsel = s_r.clk[CMSC_CLK_PRE_EN] ? s_r.clk[CMSC_CLK_BPRE_HI:CMSC_CLK_BPRE_LO] : 2'h0;
      fp = cmsc_pre_step(s_r.fpre_cnt, fsel);
      bp = cmsc_pre_step(s_r.bpre_cnt, bsel);
      s_nxt.fpre_cnt = fp.cnt;
      s_nxt.bpre_cnt = bp.cnt;

      // Filter clock: pre-scaler then fractional divider
      if (fp.tick) begin
         ff = cmsc_frac_step(s_r.facc, CMSC_FILT_RATIO[s_r.clk[CMSC_CLK_FDIV_HI:CMSC_CLK_FDIV_LO]]);
         s_nxt.facc      = ff.acc;
         s_nxt.filt_tick = ff.tick;
      end

      // Encode bit clock: pre-scaler, divider, divide by 64
      if (!s_r.clk[CMSC_CLK_ENC_EN]) begin
         s_nxt.eacc  = 16'h0000;
         s_nxt.epost = 6'h00;
      end else if (bp.tick) begin
         ef = cmsc_frac_step(s_r.eacc, CMSC_BIT_RATIO[s_r.clk[CMSC_CLK_EDIV_HI:CMSC_CLK_EDIV_LO]]);
         s_nxt.eacc = ef.acc;
         if (ef.tick) begin
            s_nxt.epost   = 6'(s_r.epost + 6'h01);
            s_nxt.enc_clk = (s_r.epost == CMSC_POST_LAST);
         end
      end

      // Decode bit clock: same chain with its own divider
      if (!s_r.clk[CMSC_CLK_DEC_EN]) begin
         s_nxt.dacc  = 16'h0000;
         s_nxt.dpost = 6'h00;
      end else if (bp.tick) begin
         df = cmsc_frac_step(s_r.dacc, CMSC_BIT_RATIO[s_r.clk[CMSC_CLK_DDIV_HI:CMSC_CLK_DDIV_LO]]);
         s_nxt.dacc = df.acc;
         if (df.tick) begin
            s_nxt.dpost   = 6'(s_r.dpost + 6'h01);
            s_nxt.dec_clk = (s_r.dpost == CMSC_POST_LAST);
         end
      end

      // Transmit scrambler, one bit per encode tick
      if (s_r.enc_clk) begin
         if (!s_r.scr[CMSC_SCR_TX_EN]) begin
            s_nxt.tx_valid = fifo_valid;
            s_nxt.tx_bit   = fifo_data;
         end else if (s_r.scr[CMSC_SCR_TX_PRBS]) begin
            s_nxt.tx_valid = 1'b1;
            s_nxt.tx_bit   = tx_fb ^ s_r.scr[CMSC_SCR_TX_INV];
            s_nxt.tx_lfsr  = {s_r.tx_lfsr[8:0], tx_fb};
         end else if (fifo_valid) begin
            sb             = fifo_data ^ tx_fb;
            s_nxt.tx_valid = 1'b1;
            s_nxt.tx_bit   = sb ^ s_r.scr[CMSC_SCR_TX_INV];
            s_nxt.tx_lfsr  = {s_r.tx_lfsr[8:0], sb};
         end
      end

      // Receive de-scrambler, one synchronised pin bit per decode tick
      if (s_r.dec_clk) begin
         s_nxt.rx_valid = 1'b1;
         if (!s_r.scr[CMSC_SCR_RX_EN]) begin
            s_nxt.rx_bit = s_r.rx_s2;
         end else if (s_r.scr[CMSC_SCR_RX_PRBS]) begin
            s_nxt.rx_bit  = rx_fb ^ s_r.scr[CMSC_SCR_RX_INV];
            s_nxt.rx_lfsr = {s_r.rx_lfsr[8:0], rx_fb};
         end else begin
            s_nxt.rx_bit  = s_r.rx_s2 ^ rx_fb ^ s_r.scr[CMSC_SCR_RX_INV];
            s_nxt.rx_lfsr = {s_r.rx_lfsr[8:0], s_r.rx_s2};
         end
      end
   end

   // State register
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         s_r         <= '0;
         s_r.mode    <= CMSC_RST_MODE;
         s_r.scr     <= CMSC_RST_SCR;
         s_r.clk     <= CMSC_RST_CLK;
         s_r.tx_lfsr <= CMSC_LFSR_SEED;
         s_r.rx_lfsr <= CMSC_LFSR_SEED;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from the state register
   assign o_reg_rdata = s_r.rdata;
   assign o_tx_valid  = s_r.tx_valid;
   assign o_tx_bit    = s_r.tx_bit;
   assign o_rx_valid  = s_r.rx_valid;
   assign o_rx_bit    = s_r.rx_bit;
   assign o_filt_tick = s_r.filt_tick;
   assign o_enc_tick  = s_r.enc_clk;
   assign o_dec_tick  = s_r.dec_clk;
   assign o_mode      = s_r.mode_dec;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);

   sequence mode_write(logic [2:0] v);
      i_reg_wr && i_reg_addr == CMSC_OFF_MODE && i_reg_wdata[2:0] == v;
   endsequence

   chk_mode_adm_buf: assert property (mode_write(3'h1) |=> ##1 o_mode.adaptive_delta_modulation && o_mode.buffered)
      else $error("mode 1 not decoded as buffered delta modulation");
   chk_mode_alaw_pcm: assert property (s_r.mode[2] |=> o_mode.alaw && o_mode.buffered && !o_mode.adaptive_delta_modulation)
      else $error("top mode bit not decoded as A-law");
   chk_tx_bypass: assert property (s_r.enc_clk && !s_r.scr[CMSC_SCR_TX_EN] && fifo_valid
      |=> o_tx_valid && o_tx_bit == $past(fifo_data))
      else $error("disabled scrambler altered data");
   chk_tx_prbs_out: assert property (s_r.enc_clk && s_r.scr[CMSC_SCR_TX_EN] && s_r.scr[CMSC_SCR_TX_PRBS]
      |=> o_tx_valid && o_tx_bit == ($past(tx_fb) ^ $past(s_r.scr[CMSC_SCR_TX_INV])))
      else $error("scrambler sequence output wrong");
   chk_tx_invert: assert property (s_r.enc_clk && s_r.scr[15:13] == 3'h5 && fifo_valid
      |=> o_tx_bit == !($past(fifo_data) ^ $past(tx_fb)))
      else $error("scrambler output not inverted");
   chk_rx_descramble: assert property (s_r.dec_clk && s_r.scr[CMSC_SCR_RX_EN] && !s_r.scr[CMSC_SCR_RX_PRBS]
      |=> o_rx_valid && o_rx_bit == ($past(s_r.rx_s2) ^ $past(rx_fb) ^ $past(s_r.scr[CMSC_SCR_RX_INV])))
      else $error("de-scrambler output wrong");
   chk_rx_prbs_out: assert property (s_r.dec_clk && s_r.scr[12:11] == 2'h3
      |=> o_rx_bit == ($past(rx_fb) ^ $past(s_r.scr[CMSC_SCR_RX_INV])))
      else $error("de-scrambler sequence output wrong");
   chk_poly_shift: assert property (s_r.enc_clk && s_r.scr[15:14] == 2'h2 && fifo_valid
      |=> s_r.tx_lfsr[0] == ($past(fifo_data) ^ $past(tx_fb)))
      else $error("scrambler history not fed with sent bit");
   chk_enc_stopped: assert property (!s_r.clk[CMSC_CLK_ENC_EN] |=> !o_enc_tick)
      else $error("encode clock runs while disabled");
   chk_dec_stopped: assert property (!s_r.clk[CMSC_CLK_DEC_EN] |=> !o_dec_tick)
      else $error("decode clock runs while disabled");
   chk_post_div64: assert property (o_enc_tick |-> s_r.epost == 6'h00 && $past(s_r.epost) == CMSC_POST_LAST)
      else $error("encode tick not at end of divide by 64");
   chk_pre_bypass: assert property (!s_r.clk[CMSC_CLK_PRE_EN] |=> s_r.bpre_cnt == 2'h0 && s_r.fpre_cnt == 2'h0)
      else $error("pre-scaler counted while disabled");

endmodule

// ==== tb/cmsc_host.sv ====
// Host model driving the register port
`timescale 1ns/100ps
module cmsc_host
   import cmsc_pkg::*;
(
   // Clock
   input  wire logic   i_clk,
   // Register port
   output logic        o_wr,
   output logic        o_rd,
   output logic [7:0]  o_addr,
   output logic [15:0] o_wdata
);
   // Idle bus at time zero
   initial begin
      o_wr    = 1'b0;
      o_rd    = 1'b0;
      o_addr  = 8'hFF;
      o_wdata = 16'h0000;
   end
   // One write; reserved mode bits stay clear, released bus shows inverse data
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge i_clk);
      o_wr    = 1'b1;
      o_addr  = a;
      o_wdata = (a == CMSC_OFF_MODE) ? {13'h0000, d[2:0]} : d;
      @(negedge i_clk);
      o_wr    = 1'b0;
      o_addr  = ~a;
      o_wdata = ~d;
   endtask
   // One read; data settles one edge after the strobe
   task automatic rd(input logic [7:0] a);
      @(negedge i_clk);
      o_rd   = 1'b1;
      o_addr = a;
      @(negedge i_clk);
      o_rd   = 1'b0;
      o_addr = ~a;
      @(negedge i_clk);
   endtask
endmodule

// ==== tb/codec_mode_scrambler_clock_cfg_tb.sv ====
// Self-checking bench for the codec configuration block
`timescale 1ns/100ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; \
   $display("wrong value %s expected %h seen %h", n, e, g); end end
module codec_mode_scrambler_clock_cfg_tb
   import cmsc_pkg::*;
;
   logic        clk, rstn, tx_v, tx_d, rx_p, wr, rd, rdy, txv, txb, rxv, rxb, ft, et, dt;
   logic [7:0]  addr;
   logic [15:0] wdata, rdata;
   cmsc_mode_t  mode;
   int          fail_count, check_count, n, dec_seen;
   logic [7:0]  pat = 8'hB4;
   logic [7:0]  rows [8] = '{8'h10, 8'h38, 8'h4C, 8'h6A, 8'h89, 8'hA9, 8'hC9, 8'hE9};
   wire  [4:0]  tk = {rxv, txv, dt, et, ft};
   cmsc_host host (.i_clk(clk), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
   cmsc_top #(.FIFO_DEPTH(8)) dut (.i_clk(clk), .i_resetn(rstn), .i_reg_wr(wr), .i_reg_rd(rd),
      .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_tx_valid(tx_v),
      .i_tx_data(tx_d), .o_tx_ready(rdy), .o_tx_valid(txv), .o_tx_bit(txb), .i_rx_pin(rx_p),
      .o_rx_valid(rxv), .o_rx_bit(rxb), .o_filt_tick(ft), .o_enc_tick(et), .o_dec_tick(dt),
      .o_mode(mode));
   // Clock, 8 ns period
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Decode ticks seen, to show a stopped clock
   always @(posedge clk) if (dt === 1'b1) dec_seen++;
   // Verdict and end of run
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // Bounded wait for a pulse on tk[w]; n holds the cycles waited
   task automatic wt(input int w);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (tk[w] !== 1'b1 && n < 4000);
      if (n >= 4000) begin
         fail_count++;
         summarize();
      end
   endtask
   // Main sequence
   initial begin
      rstn = 1'b0;
      tx_v = 1'b0;
      tx_d = 1'b0;
      rx_p = 1'b0;
      repeat (4) @(negedge clk);
      `CHK("ready in reset", 1'b1, rdy)
      rstn = 1'b1;
      @(negedge clk);
      `CHK("mode after reset", 5'h10, mode)
      host.rd(CMSC_OFF_CLK);
      `CHK("clk reset", CMSC_RST_CLK, rdata)
      for (int i = 0; i < 8; i++) begin
         host.wr(CMSC_OFF_MODE, {13'h0000, rows[i][7:5]});
         repeat (2) @(negedge clk);
         `CHK("mode decode", rows[i][4:0], mode)
      end
      host.rd(CMSC_OFF_MODE);
      `CHK("mode read", 16'h0007, rdata)
      host.wr(CMSC_OFF_SCR, 16'h5A5A);
      host.rd(CMSC_OFF_SCR);
      `CHK("scr read", 16'h5A5A, rdata)
      host.rd(8'h74);
      `CHK("unmapped read", 16'h0000, rdata)
      // Fill the buffer back to back with the encode clock stopped
      for (int i = 0; i < 8; i++) begin
         @(negedge clk);
         tx_v = 1'b1;
         tx_d = pat[i];
      end
      @(negedge clk);
      tx_d = 1'b0;
      repeat (2) @(negedge clk);
      `CHK("ready when full", 1'b0, rdy)
      tx_v = 1'b0;
      host.wr(CMSC_OFF_CLK, 16'h2000);
      for (int i = 0; i < 8; i++) begin
         wt(3);
         `CHK("tx bit", pat[i], txb)
      end
      host.wr(CMSC_OFF_SCR, 16'hA000);
      @(negedge clk);
      tx_v = 1'b1;
      tx_d = 1'b1;
      @(negedge clk);
      tx_v = 1'b0;
      wt(3);
      `CHK("tx inverted", 1'b0, txb)
      host.wr(CMSC_OFF_SCR, 16'hE000);
      wt(3);
      `CHK("tx sequence", 1'b1, txb)
      // Clock chain periods
      host.wr(CMSC_OFF_CLK, 16'h1100);
      repeat (2) wt(0);
      `CHK("filter bypass", 4, n)
      host.wr(CMSC_OFF_CLK, 16'h9100);
      repeat (2) wt(0);
      `CHK("filter period", 12, n)
      host.wr(CMSC_OFF_CLK, 16'hA042);
      dec_seen = 0;
      repeat (3) wt(1);
      `CHK("encode period", 288, n)
      `CHK("decode stopped", 0, dec_seen)
      // Receive path
      rx_p = 1'b1;
      host.wr(CMSC_OFF_SCR, 16'h0000);
      host.wr(CMSC_OFF_CLK, 16'h4008);
      repeat (2) wt(2);
      `CHK("decode period", 128, n)
      repeat (2) wt(4);
      `CHK("rx plain", 1'b1, rxb)
      host.wr(CMSC_OFF_SCR, 16'h1400);
      repeat (2) wt(4);
      `CHK("rx inverted", 1'b0, rxb)
      host.wr(CMSC_OFF_SCR, 16'h1C00);
      repeat (2) wt(4);
      `CHK("rx sequence", 1'b1, rxb)
      host.wr(CMSC_OFF_SCR, 16'h1001);
      repeat (3) wt(4);
      `CHK("rx tap", 1'b0, rxb)
      summarize();
   end
endmodule
